// ==== design/lsoc_link_os_coding.sv ====
`timescale 1ns/1ns
`include "lsoc_consts.svh"
module lsoc_link_os_coding import lsoc_pkg::*; #(
    parameter bit LOOP_SUPPORT  = 1'b1,
    parameter bit FABRIC_PORT   = 1'b0,
    parameter bit TRAIN_SUPPORT = 1'b1,
    parameter int LOCK_GOOD     = `LSOC_LOCK_GOOD,
    parameter int LOCK_BAD      = `LSOC_LOCK_BAD
) (
    input  wire logic        clock,
    input  wire logic        sys_rst,
    input  wire logic        frameValid,
    input  lsoc_word_t       frameWord,
    output logic             frameReady,
    input  lsoc_sig_t        sigReq,
    input  lsoc_seq_t        seqReq,
    input  wire logic [15:0] loopAddr,
    input  wire logic        respSeqMode,
    input  wire logic        txRdNeg,
    output lsoc_word_t       txWord,
    input  wire logic        rxValid,
    input  lsoc_word_t       rxWord,
    output logic             rxIdle,
    output logic             rxRrdy,
    output logic             rxFill,
    output lsoc_seq_t        rxSeq,
    output logic             fwdValid,
    output lsoc_word_t       fwdWord,
    input  wire logic        trainDone,
    input  wire logic        localFecReq,
    input  wire logic        peerFecReq,
    output logic             fecOn,
    input  wire logic [63:0] txBody,
    input  wire logic        txBodyCtl,
    output logic             txBodyTake,
    output logic             serTxBit,
    input  wire logic        serRxBit,
    output logic [65:0]      rxBlk,
    output logic             rxBlkValid,
    output logic             rxLocked
);
    // ==========================================================
    // Ordered set helpers
    function automatic lsoc_word_t osWord(input logic [7:0] c2, c3, c4);
        lsoc_word_t w;
        w.isK  = `LSOC_OS_KMASK;
        w.data = {`LSOC_K28_5, c2, c3, c4};
        return w;
    endfunction

    function automatic logic isOs(input lsoc_word_t w);
        return (w.isK == `LSOC_OS_KMASK) && (w.data[31:24] == `LSOC_K28_5);
    endfunction

    function automatic lsoc_word_t encSeq(input lsoc_seq_t s, input logic [15:0] ad);
        lsoc_word_t w;
        // Only the negative beginning form is ever produced
        case (s)
            SEQ_NOS: w = osWord(`LSOC_D21_2, `LSOC_D31_5, `LSOC_D5_2);
            SEQ_OLS: w = osWord(`LSOC_D21_1, `LSOC_D10_4, `LSOC_D21_2);
            SEQ_LR:  w = osWord(`LSOC_D9_2, `LSOC_D31_5, `LSOC_D9_2);
            SEQ_LRR: w = osWord(`LSOC_D21_1, `LSOC_D31_5, `LSOC_D9_2);
            SEQ_LIP: w = osWord(`LSOC_D21_0, ad[15:8], ad[7:0]);
            SEQ_LPB: w = osWord(`LSOC_D9_0, ad[15:8], ad[7:0]);
            SEQ_LPE: w = osWord(`LSOC_D5_0, ad[15:8], ad[7:0]);
            default: w = osWord(`LSOC_D21_4, `LSOC_D21_5, `LSOC_D21_5);
        endcase
        return w;
    endfunction

    function automatic lsoc_seq_t decSeq(input lsoc_word_t w);
        lsoc_seq_t s;
        s = SEQ_NONE;
        if (isOs(w)) begin
            if (w.data[23:0] == {`LSOC_D21_2, `LSOC_D31_5, `LSOC_D5_2}) s = SEQ_NOS;
            else if (w.data[23:0] == {`LSOC_D21_1, `LSOC_D10_4, `LSOC_D21_2}) s = SEQ_OLS;
            else if (w.data[23:0] == {`LSOC_D9_2, `LSOC_D31_5, `LSOC_D9_2}) s = SEQ_LR;
            else if (w.data[23:0] == {`LSOC_D21_1, `LSOC_D31_5, `LSOC_D9_2}) s = SEQ_LRR;
            else if (LOOP_SUPPORT && w.data[23:16] == `LSOC_D21_0) s = SEQ_LIP;
            else if (LOOP_SUPPORT && w.data[23:16] == `LSOC_D9_0) s = SEQ_LPB;
            else if (LOOP_SUPPORT && w.data[23:16] == `LSOC_D5_0) s = SEQ_LPE;
        end
        return s;
    endfunction

    // Loop families are dropped when loop operation is absent
    function automatic lsoc_seq_t seqAllowed(input lsoc_seq_t s);
        if (!LOOP_SUPPORT && (s == SEQ_LIP || s == SEQ_LPB || s == SEQ_LPE)) begin
            return SEQ_NONE;
        end
        return s;
    endfunction

    function automatic lsoc_seq_t respond(input lsoc_seq_t s);
        case (s)
            SEQ_NOS: return SEQ_OLS;
            SEQ_OLS: return SEQ_LR;
            SEQ_LR:  return SEQ_LRR;
            SEQ_LIP, SEQ_LPB, SEQ_LPE: return s;
            default: return SEQ_NONE;
        endcase
    endfunction

    localparam lsoc_word_t IDLE_W = osWord(`LSOC_D21_4, `LSOC_D21_5, `LSOC_D21_5);
    localparam lsoc_word_t RRDY_W = osWord(`LSOC_D21_4, `LSOC_D10_2, `LSOC_D10_2);

    // ==========================================================
    // Transmit selection
    lsoc_tkind_t txKind_r, txKind_nxt;
    lsoc_word_t  txWord_nxt;
    lsoc_seq_t   seqWant;
    logic [1:0]  fillRun_r, fillRun_nxt, postOwe_r, postOwe_nxt;
    logic        frameReady_nxt;

    always_comb begin
        // A request from the port logic outranks the automatic response
        if (seqAllowed(seqReq) != SEQ_NONE) begin
            seqWant = seqAllowed(seqReq);
        end else if (respSeqMode) begin
            seqWant = respond(rxSeq);
        end else begin
            seqWant = SEQ_NONE;
        end
        if (frameValid && frameReady) begin
            txKind_nxt = TK_FRAME;
            txWord_nxt = frameWord;
        end else if (seqWant != SEQ_NONE && txRdNeg && postOwe_r == 2'h0) begin
            txKind_nxt = TK_SEQ;
            txWord_nxt = encSeq(seqWant, loopAddr);
        end else if (sigReq != SIG_NONE && txRdNeg && fillRun_r == `LSOC_FILL_MIN
                     && postOwe_r == 2'h0) begin
            txKind_nxt = TK_SIG;
            txWord_nxt = (sigReq == SIG_RRDY) ? RRDY_W : IDLE_W;
        end else begin
            // Positive disparity after frame data also lands here
            txKind_nxt = TK_FILL;
            txWord_nxt = IDLE_W;
        end
        if (txKind_nxt != TK_FILL) begin
            fillRun_nxt = 2'h0;
        end else if (fillRun_r == `LSOC_FILL_MIN) begin
            fillRun_nxt = fillRun_r;
        end else begin
            fillRun_nxt = fillRun_r + 2'h1;
        end
        if (txKind_nxt == TK_SIG) begin
            postOwe_nxt = `LSOC_FILL_MIN;
        end else if (txKind_nxt == TK_FILL && postOwe_r != 2'h0) begin
            postOwe_nxt = postOwe_r - 2'h1;
        end else begin
            postOwe_nxt = postOwe_r;
        end
        // Frames also wait out the trailing fill words
        frameReady_nxt = (postOwe_nxt == 2'h0);
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            txKind_r   <= TK_FILL;
            txWord     <= IDLE_W;
            fillRun_r  <= 2'h0;
            postOwe_r  <= 2'h0;
            frameReady <= 1'b1;
        end else begin
            txKind_r   <= txKind_nxt;
            txWord     <= txWord_nxt;
            fillRun_r  <= fillRun_nxt;
            postOwe_r  <= postOwe_nxt;
            frameReady <= frameReady_nxt;
        end
    end

    a_sig_prefill: assert property (@(posedge clock) disable iff (sys_rst)
        txKind_r == TK_SIG |-> $past(txKind_r) == TK_FILL && $past(txKind_r, 2) == TK_FILL)
        else $error("signal not preceded by two fill words");

    a_sig_postfill: assert property (@(posedge clock) disable iff (sys_rst)
        txKind_r == TK_SIG |=> (txKind_r == TK_FILL && txWord == IDLE_W) [*2])
        else $error("signal not followed by two fill words");

    a_os_rdneg: assert property (@(posedge clock) disable iff (sys_rst)
        (txKind_r == TK_SIG || txKind_r == TK_SEQ) |-> $past(txRdNeg))
        else $error("ordered set started at positive disparity");

    a_idle_default: assert property (@(posedge clock) disable iff (sys_rst)
        (!$past(frameValid) && $past(seqReq) == SEQ_NONE && !$past(respSeqMode)
         && $past(sigReq) == SIG_NONE) |-> txWord == IDLE_W)
        else $error("idle not sent while nothing is pending");

    a_seq_repeat: assert property (@(posedge clock) disable iff (sys_rst)
        ($past(seqReq) == SEQ_LR && $past(txRdNeg) && !$past(frameValid) && $past(frameReady))
        |-> txWord == osWord(`LSOC_D9_2, `LSOC_D31_5, `LSOC_D9_2))
        else $error("requested sequence not sent continuously");

    a_frame_hold: assert property (@(posedge clock) disable iff (sys_rst)
        !frameReady |=> txKind_r != TK_FRAME)
        else $error("frame sent while fill words owed");

    a_nos_code: assert property (@(posedge clock) disable iff (sys_rst)
        ($past(seqReq) == SEQ_NOS && $past(txRdNeg && frameReady && !frameValid))
        |-> txWord == osWord(`LSOC_D21_2, `LSOC_D31_5, `LSOC_D5_2))
        else $error("not-operational sequence encoded wrongly");

    // ==========================================================
    // Receive recognition
    lsoc_word_t  last_r, last_nxt, fwdWord_nxt;
    lsoc_seq_t   cand, rxSeq_nxt;
    logic [1:0]  match_r, match_nxt;
    logic        rxIdle_nxt, rxRrdy_nxt, rxFill_nxt, fwdValid_nxt;

    always_comb begin
        cand         = decSeq(rxWord);
        last_nxt     = last_r;
        match_nxt    = match_r;
        rxSeq_nxt    = rxSeq;
        rxIdle_nxt   = 1'b0;
        rxRrdy_nxt   = 1'b0;
        rxFill_nxt   = 1'b0;
        fwdValid_nxt = 1'b0;
        fwdWord_nxt  = fwdWord;
        if (rxValid) begin
            // Signals are taken from a single set, whatever surrounds them
            rxRrdy_nxt = (rxWord == RRDY_W);
            rxIdle_nxt = (rxWord == IDLE_W);
            rxFill_nxt = isOs(rxWord) && cand == SEQ_NONE && !rxRrdy_nxt;
            if (cand != SEQ_NONE && rxWord == last_r) begin
                if (match_r != `LSOC_SEQ_MATCH) begin
                    match_nxt = match_r + 2'h1;
                end
            end else if (cand != SEQ_NONE) begin
                match_nxt = 2'h1;
            end else begin
                match_nxt = 2'h0;
            end
            last_nxt = rxWord;
            if (match_nxt == `LSOC_SEQ_MATCH) begin
                rxSeq_nxt = cand;
            end else if (match_nxt != match_r + 2'h1 || cand == SEQ_NONE) begin
                rxSeq_nxt = SEQ_NONE;
            end
            // Sequences from the node port stop here on a fabric port
            fwdValid_nxt = !(FABRIC_PORT && cand != SEQ_NONE);
            fwdWord_nxt  = rxWord;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            last_r   <= IDLE_W;
            match_r  <= 2'h0;
            rxSeq    <= SEQ_NONE;
            rxIdle   <= 1'b0;
            rxRrdy   <= 1'b0;
            rxFill   <= 1'b0;
            fwdValid <= 1'b0;
            fwdWord  <= IDLE_W;
        end else begin
            last_r   <= last_nxt;
            match_r  <= match_nxt;
            rxSeq    <= rxSeq_nxt;
            rxIdle   <= rxIdle_nxt;
            rxRrdy   <= rxRrdy_nxt;
            rxFill   <= rxFill_nxt;
            fwdValid <= fwdValid_nxt;
            fwdWord  <= fwdWord_nxt;
        end
    end

    a_rrdy_detect: assert property (@(posedge clock) disable iff (sys_rst)
        (rxValid && rxWord == RRDY_W) |=> rxRrdy && !rxFill)
        else $error("receiver ready set not recognized");

    a_unknown_fill: assert property (@(posedge clock) disable iff (sys_rst)
        (rxValid && isOs(rxWord) && decSeq(rxWord) == SEQ_NONE && rxWord != RRDY_W)
        |=> rxFill)
        else $error("unrecognized ordered set not handled as fill");

    a_seq_three: assert property (@(posedge clock) disable iff (sys_rst)
        (rxSeq != SEQ_NONE && $past(rxSeq) == SEQ_NONE)
        |-> $past(rxValid) && $past(last_r) == $past(rxWord) && match_r == `LSOC_SEQ_MATCH)
        else $error("sequence recognized before three matches");

    a_seq_restart: assert property (@(posedge clock) disable iff (sys_rst)
        (rxValid && !isOs(rxWord)) |=> match_r == 2'h0 && rxSeq == SEQ_NONE)
        else $error("data did not restart sequence matching");

    a_fabric_drop: assert property (@(posedge clock) disable iff (sys_rst)
        (FABRIC_PORT && rxValid && decSeq(rxWord) != SEQ_NONE) |=> !fwdValid)
        else $error("fabric port forwarded a primitive sequence");

    a_idle_detect: assert property (@(posedge clock) disable iff (sys_rst)
        (rxValid && rxWord == IDLE_W) |=> rxIdle && rxFill)
        else $error("idle set not recognized as fill");

    a_rx_quiet: assert property (@(posedge clock) disable iff (sys_rst)
        !rxValid |=> !rxIdle && !rxRrdy && !rxFill && !fwdValid && $stable(rxSeq))
        else $error("receive outputs changed without a valid word");

    a_fwd_copy: assert property (@(posedge clock) disable iff (sys_rst)
        (rxValid && decSeq(rxWord) == SEQ_NONE) |=> fwdValid && fwdWord == $past(rxWord))
        else $error("received word not copied onward");

    a_seq_level: assert property (@(posedge clock) disable iff (sys_rst)
        (match_r == `LSOC_SEQ_MATCH) == (rxSeq != SEQ_NONE))
        else $error("recognized sequence out of step with match count");

    // ==========================================================
    // Error correction agreement
    logic fecOn_nxt;

    always_comb begin
        // Both directions follow one agreed decision
        fecOn_nxt = TRAIN_SUPPORT && trainDone && localFecReq && peerFecReq;
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            fecOn <= 1'b0;
        end else begin
            fecOn <= fecOn_nxt;
        end
    end

    a_fec_train: assert property (@(posedge clock) disable iff (sys_rst)
        fecOn |-> TRAIN_SUPPORT && $past(trainDone) && $past(localFecReq && peerFecReq))
        else $error("error correction enabled without agreement");

    a_fec_refuse: assert property (@(posedge clock) disable iff (sys_rst)
        !(localFecReq && peerFecReq) |=> !fecOn)
        else $error("error correction enabled without both requests");

    // ==========================================================
    // 66-bit word path
    lsoc_blk_serdes #(
        .LOCK_GOOD (LOCK_GOOD),
        .LOCK_BAD  (LOCK_BAD)
    ) uBlk (
        .clock      (clock),
        .sys_rst    (sys_rst),
        .txBody     (txBody),
        .txBodyCtl  (txBodyCtl),
        .txBodyTake (txBodyTake),
        .txBit      (serTxBit),
        .rxBit      (serRxBit),
        .rxBlk      (rxBlk),
        .rxBlkValid (rxBlkValid),
        .rxLocked   (rxLocked)
    );
endmodule

// ==== design/lsoc_consts.svh ====
// ==========================================================
`ifndef LSOC_CONSTS_SVH
`define LSOC_CONSTS_SVH

// ==========================================================
// Transmission characters
`define LSOC_K28_5        8'hBC
`define LSOC_D21_4        8'h95
`define LSOC_D21_5        8'hB5
`define LSOC_D10_2        8'h4A
`define LSOC_D21_2        8'h55
`define LSOC_D31_5        8'hBF
`define LSOC_D5_2         8'h45
`define LSOC_D21_1        8'h35
`define LSOC_D10_4        8'h8A
`define LSOC_D9_2         8'h49
`define LSOC_D21_0        8'h15
`define LSOC_D9_0         8'h09
`define LSOC_D5_0         8'h05
`define LSOC_OS_KMASK     4'h8

// ==========================================================
// Counts
`define LSOC_FILL_MIN     2'h2
`define LSOC_SEQ_MATCH    2'h3
`define LSOC_SH_DATA      2'h2
`define LSOC_SH_CTRL      2'h1
`define LSOC_BLK_LAST     7'h41
`define LSOC_LOCK_GOOD    64
`define LSOC_LOCK_BAD     16

`endif

// ==== design/lsoc_pkg.sv ====
package lsoc_pkg;
    typedef struct packed {
        logic [3:0]  isK;
        logic [31:0] data;
    } lsoc_word_t;

    typedef enum logic [2:0] {
        SEQ_NONE, SEQ_NOS, SEQ_OLS, SEQ_LR, SEQ_LRR, SEQ_LIP, SEQ_LPB, SEQ_LPE
    } lsoc_seq_t;

    typedef enum logic [1:0] {SIG_NONE, SIG_IDLE, SIG_RRDY} lsoc_sig_t;

    typedef enum {TK_FILL, TK_FRAME, TK_SIG, TK_SEQ} lsoc_tkind_t;

    typedef enum {RX_HUNT, RX_LOCK} lsoc_rxst_t;
endpackage

// ==== design/lsoc_blk_serdes.sv ====
`timescale 1ns/1ns
`include "lsoc_consts.svh"
module lsoc_blk_serdes import lsoc_pkg::*; #(
    parameter int LOCK_GOOD = `LSOC_LOCK_GOOD,
    parameter int LOCK_BAD  = `LSOC_LOCK_BAD
) (
    input  wire logic        clock,
    input  wire logic        sys_rst,
    input  wire logic [63:0] txBody,
    input  wire logic        txBodyCtl,
    output logic             txBodyTake,
    output logic             txBit,
    input  wire logic        rxBit,
    output logic [65:0]      rxBlk,
    output logic             rxBlkValid,
    output logic             rxLocked
);
    localparam int CW = $clog2(LOCK_GOOD + 1);

    // ==========================================================
    // Transmit serializer
    logic [65:0] txSh_r, txSh_nxt;
    logic [6:0]  txCnt_r, txCnt_nxt;
    logic        txBit_nxt, txTake_nxt;

    always_comb begin
        txCnt_nxt  = (txCnt_r == `LSOC_BLK_LAST) ? 7'h00 : txCnt_r + 7'h01;
        txTake_nxt = (txCnt_r == 7'h00);
        txBit_nxt  = txSh_r[0];
        if (txCnt_r == 7'h00) begin
            // Body arrives already scrambled; header is appended clear
            txSh_nxt = {txBody, txBodyCtl ? `LSOC_SH_CTRL : `LSOC_SH_DATA};
        end else begin
            txSh_nxt = {1'b0, txSh_r[65:1]};
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            txSh_r     <= 66'h0;
            txCnt_r    <= 7'h00;
            txBit      <= 1'b0;
            txBodyTake <= 1'b0;
        end else begin
            txSh_r     <= txSh_nxt;
            txCnt_r    <= txCnt_nxt;
            txBit      <= txBit_nxt;
            txBodyTake <= txTake_nxt;
        end
    end

    a_hdr_valid: assert property (@(posedge clock) disable iff (sys_rst)
        txBodyTake |-> txSh_r[0] != txSh_r[1])
        else $error("loaded word has an invalid sync header");

    a_lsb_first: assert property (@(posedge clock) disable iff (sys_rst)
        txBodyTake |=> txBit == $past(txSh_r[0]) ##1 txBit == $past(txSh_r[1], 2))
        else $error("word not sent least significant bit first");

    // ==========================================================
    // Receive word alignment
    logic       rxS1_r, rxS2_r;
    logic [65:0] rxSr_r, rxSr_nxt, rxBlk_nxt;
    logic [6:0]  rxCnt_r, rxCnt_nxt;
    logic [CW-1:0] good_r, good_nxt;
    lsoc_rxst_t  rxSt_r, rxSt_nxt;
    logic        hdrOk, evalNow, rxBlkValid_nxt, rxLocked_nxt;

    always_comb begin
        rxSr_nxt       = {rxS2_r, rxSr_r[65:1]};
        evalNow        = (rxCnt_r == 7'h00);
        hdrOk          = rxSr_r[0] ^ rxSr_r[1];
        rxCnt_nxt      = (rxCnt_r == `LSOC_BLK_LAST) ? 7'h00 : rxCnt_r + 7'h01;
        rxSt_nxt       = rxSt_r;
        good_nxt       = good_r;
        rxBlk_nxt      = rxBlk;
        rxBlkValid_nxt = 1'b0;
        if (evalNow) begin
            case (rxSt_r)
                RX_HUNT: begin
                    if (!hdrOk) begin
                        // Hold the count so the boundary moves one bit
                        rxCnt_nxt = 7'h00;
                        good_nxt  = '0;
                    end else if (good_r == CW'(LOCK_GOOD - 1)) begin
                        rxSt_nxt = RX_LOCK;
                        good_nxt = '0;
                    end else begin
                        good_nxt = good_r + 1'b1;
                    end
                end
                RX_LOCK: begin
                    rxBlk_nxt      = rxSr_r;
                    rxBlkValid_nxt = 1'b1;
                    if (hdrOk) begin
                        good_nxt = '0;
                    end else if (good_r == CW'(LOCK_BAD - 1)) begin
                        rxSt_nxt = RX_HUNT;
                        good_nxt = '0;
                    end else begin
                        good_nxt = good_r + 1'b1;
                    end
                end
                default: rxSt_nxt = RX_HUNT;
            endcase
        end
        rxLocked_nxt = (rxSt_nxt == RX_LOCK);
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rxS1_r     <= 1'b0;
            rxS2_r     <= 1'b0;
            rxSr_r     <= 66'h0;
            rxCnt_r    <= 7'h00;
            good_r     <= '0;
            rxSt_r     <= RX_HUNT;
            rxBlk      <= 66'h0;
            rxBlkValid <= 1'b0;
            rxLocked   <= 1'b0;
        end else begin
            rxS1_r     <= rxBit;
            rxS2_r     <= rxS1_r;
            rxSr_r     <= rxSr_nxt;
            rxCnt_r    <= rxCnt_nxt;
            good_r     <= good_nxt;
            rxSt_r     <= rxSt_nxt;
            rxBlk      <= rxBlk_nxt;
            rxBlkValid <= rxBlkValid_nxt;
            rxLocked   <= rxLocked_nxt;
        end
    end

    a_hunt_slip: assert property (@(posedge clock) disable iff (sys_rst)
        (rxSt_r == RX_HUNT && evalNow && !hdrOk) |=> rxCnt_r == 7'h00 && !rxLocked)
        else $error("hunting aligner did not slip on a bad header");
endmodule

// ==== tb/lsoc_peer_model.sv ====
`timescale 1ns/1ns
module lsoc_peer_model import lsoc_pkg::*; (
    input  wire logic  clock,
    input  wire logic  sys_rst,
    input  lsoc_word_t sendWord,
    input  wire logic  sendValid,
    output logic       rxValid,
    output lsoc_word_t rxWord,
    output logic       serRxBit
);
    // ========
    // Peer streams
    lsoc_word_t  lastWord_r = '0;
    logic [65:0] blk_r      = '0;
    logic [6:0]  cnt_r      = 7'h00;
    logic [31:0] seed_r     = 32'h5A3C;
    assign rxValid = sendValid;
    // Idle word lines invert the last word so stale data never matches
    assign rxWord = sendValid ? sendWord : ~lastWord_r;
    assign serRxBit = blk_r[0];
    always @(negedge clock) begin
        if (sendValid) lastWord_r <= sendWord;
        seed_r <= {seed_r[30:0], seed_r[31] ^ seed_r[21] ^ seed_r[1] ^ seed_r[0]};
        cnt_r <= (sys_rst || cnt_r == 7'h41) ? 7'h00 : cnt_r + 7'h01;
        blk_r <= (sys_rst || cnt_r == 7'h41) ? {seed_r, ~seed_r, 2'h2} : blk_r >> 1;
    end
endmodule

// ==== tb/lsoc_link_os_coding_tb.sv ====
`timescale 1ns/1ns
module lsoc_link_os_coding_tb import lsoc_pkg::*;;
    // ========
    // Stimulus
    logic        clock = 1'b0, sys_rst = 1'b1, txRdNeg = 1'b1, respSeqMode = 1'b0;
    logic        frameValid = 1'b0, trainDone = 1'b0, localFecReq = 1'b0, peerFecReq = 1'b0;
    logic        txBodyCtl = 1'b1, sendValid = 1'b0, frameReady, rxIdle, rxRrdy, rxFill;
    logic        fwdValid, fecOn, txBodyTake, serTxBit, serRxBit, rxValid, rxBlkValid, rxLocked;
    logic [15:0] loopAddr = 16'h0000;
    logic [63:0] txBody = 64'h0;
    logic [65:0] rxBlk, got;
    logic [31:0] rnd = 32'h84F7;
    lsoc_word_t  frameWord = '0, sendWord = '0, txWord, rxWord, fwdWord;
    lsoc_word_t  idleW, rrdyW;
    lsoc_sig_t   sigReq = SIG_NONE;
    lsoc_seq_t   seqReq = SEQ_NONE, rxSeq;
    int          bad_count = 0, samples_checked = 0;
    initial forever #2 clock = ~clock;
    lsoc_link_os_coding #(.LOCK_GOOD(16), .LOCK_BAD(2)) uut (.clock(clock), .sys_rst(sys_rst),
        .frameValid(frameValid), .frameWord(frameWord), .frameReady(frameReady),
        .sigReq(sigReq), .seqReq(seqReq), .loopAddr(loopAddr), .respSeqMode(respSeqMode),
        .txRdNeg(txRdNeg), .txWord(txWord), .rxValid(rxValid), .rxWord(rxWord),
        .rxIdle(rxIdle), .rxRrdy(rxRrdy), .rxFill(rxFill), .rxSeq(rxSeq), .fwdValid(fwdValid),
        .fwdWord(fwdWord), .trainDone(trainDone), .localFecReq(localFecReq),
        .peerFecReq(peerFecReq), .fecOn(fecOn), .txBody(txBody), .txBodyCtl(txBodyCtl),
        .txBodyTake(txBodyTake), .serTxBit(serTxBit), .serRxBit(serRxBit), .rxBlk(rxBlk),
        .rxBlkValid(rxBlkValid), .rxLocked(rxLocked));
    lsoc_peer_model peer (.clock(clock), .sys_rst(sys_rst), .sendWord(sendWord),
        .sendValid(sendValid), .rxValid(rxValid), .rxWord(rxWord), .serRxBit(serRxBit));
    // ========
    // Helpers
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic lsoc_word_t os(input logic [7:0] b, input logic [7:0] c, d);
        return {4'h8, 8'hBC, b, c, d};
    endfunction
    function automatic lsoc_word_t seqW(input lsoc_seq_t s, input logic [15:0] a);
        case (s)
            SEQ_NOS: return os(8'h55, 8'hBF, 8'h45);
            SEQ_OLS: return os(8'h35, 8'h8A, 8'h55);
            SEQ_LR:  return os(8'h49, 8'hBF, 8'h49);
            SEQ_LRR: return os(8'h35, 8'hBF, 8'h49);
            SEQ_LIP: return os(8'h15, a[15:8], a[7:0]);
            SEQ_LPB: return os(8'h09, a[15:8], a[7:0]);
            SEQ_LPE: return os(8'h05, a[15:8], a[7:0]);
            default: return os(8'h95, 8'hB5, 8'hB5);
        endcase
    endfunction
    task automatic chk(input string n, input logic [65:0] e, input logic [65:0] g);
        samples_checked++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic print_verdict();
        $display("checked %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // Waits on take, lock, block valid or a given transmit word
    task automatic waitFor(input int sel, input int lim, input lsoc_word_t e = '0);
        logic f;
        for (int k = 0; k <= lim; k++) begin
            f = sel == 0 ? txBodyTake : sel == 1 ? rxLocked : sel == 2 ? rxBlkValid : txWord === e;
            if (f === 1'b1) begin
                samples_checked++;
                return;
            end
            @(negedge clock);
        end
        bad_count++;
        $display("ERROR wait%0d exp event got timeout", sel);
        print_verdict();
    endtask
    task automatic rx(input lsoc_word_t w, input logic v);
        sendWord = w;
        sendValid = v;
        @(negedge clock);
    endtask
    // ========
    // Scenarios
    initial begin
        idleW = seqW(SEQ_NONE, 16'h0);
        rrdyW = os(8'h95, 8'h4A, 8'h4A);
        repeat (8) @(negedge clock);
        sys_rst = 1'b0;
        chk("idle", idleW, txWord);
        for (int i = 1; i < 8; i++) begin
            rnd = lfsr(rnd);
            loopAddr = rnd[15:0];
            seqReq = lsoc_seq_t'(i);
            repeat (2) begin
                @(negedge clock);
                chk("seqWord", seqW(seqReq, loopAddr), txWord);
            end
        end
        txRdNeg = 1'b0;
        seqReq = SEQ_LR;
        @(negedge clock);
        chk("heldSeq", idleW, txWord);
        seqReq = SEQ_NONE;
        sigReq = SIG_RRDY;
        @(negedge clock);
        chk("heldSig", idleW, txWord);
        txRdNeg = 1'b1;
        waitFor(3, 6, rrdyW);
        sigReq = SIG_NONE;
        chk("frameReady", 1'b0, frameReady);
        rnd = lfsr(rnd);
        frameWord = {4'h0, rnd};
        frameValid = 1'b1;
        repeat (2) begin
            @(negedge clock);
            chk("fillAfter", idleW, txWord);
        end
        waitFor(3, 3, frameWord);
        frameValid = 1'b0;
        $display("test transmit done");
        for (int i = 0; i < 8; i++) begin
            rnd = lfsr(rnd);
            {trainDone, localFecReq, peerFecReq} = (i == 0) ? 3'h7 : rnd[2:0];
            @(negedge clock);
            chk("fecOn", &{trainDone, localFecReq, peerFecReq}, fecOn);
        end
        rx(idleW, 1'b1);
        chk("rxIdle", 2'h3, {rxIdle, rxFill});
        rx({4'h0, rnd}, 1'b1);
        chk("fwdWord", {1'b1, 4'h0, rnd}, {fwdValid, fwdWord});
        rx(rrdyW, 1'b1);
        chk("rxRrdy", 2'h2, {rxRrdy, rxFill});
        rx(os(8'hB5, 8'h55, 8'h55), 1'b1);
        chk("rxFill", 1'b1, rxFill);
        repeat (2) rx(seqW(SEQ_NOS, 16'h0), 1'b1);
        chk("rxSeq2", SEQ_NONE, rxSeq);
        rx(idleW, 1'b0);
        rx(seqW(SEQ_NOS, 16'h0), 1'b1);
        chk("rxSeq3", SEQ_NOS, rxSeq);
        rx({4'h0, rnd}, 1'b1);
        chk("rxSeqData", SEQ_NONE, rxSeq);
        repeat (2) rx(seqW(SEQ_NOS, 16'h0), 1'b1);
        repeat (2) rx(seqW(SEQ_OLS, 16'h0), 1'b1);
        chk("rxSeqDiff", SEQ_NONE, rxSeq);
        rx(seqW(SEQ_OLS, 16'h0), 1'b1);
        chk("rxSeqOls", SEQ_OLS, rxSeq);
        respSeqMode = 1'b1;
        repeat (3) rx(seqW(SEQ_LR, 16'h0), 1'b1);
        waitFor(3, 4, seqW(SEQ_LRR, 16'h0));
        respSeqMode = 1'b0;
        repeat (2) rx(seqW(SEQ_LR, 16'h0), 1'b1);
        chk("respIdle", idleW, txWord);
        rx(idleW, 1'b0);
        $display("test receive done");
        for (int j = 0; j < 2; j++) begin
            rnd = lfsr(rnd);
            txBodyCtl = (j == 0);
            txBody = {rnd, lfsr(rnd)};
            @(negedge clock);
            waitFor(0, 70);
            for (int b = 0; b < 66; b++) begin
                @(negedge clock);
                got[b] = serTxBit;
            end
            chk("serWord", {txBody, txBodyCtl ? 2'h1 : 2'h2}, got);
        end
        waitFor(1, 20000);
        waitFor(2, 70);
        chk("rxHdr", 2'h2, rxBlk[1:0]);
        $display("test serial done");
        print_verdict();
    end
endmodule
